// ==== ctp_pkg.sv ====
// Constants, register map and shared helpers for the cascadable timer pair
//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Pair-join bit set joins timers into 32 bits
// - Upper count holds high word, lower low word
// - Joined: lower control steers, upper control ignored except its idle-stop bit
// - Joined: only upper interrupt controls signal events
// - Fixed pairing: lower-word timer with upper-word timer
// - Joined period is upper word over lower word
// - Timer, gated timer, synchronous counter modes
// - Run bit starts pair or own timer
// - Idle-stop bit halts timer during idle
// - Joined pair idles per upper idle-stop bit
// - Gate enable works only with internal clock
// - Prescale 1:1, 1:8, 1:64, 1:256 by field
// - Clock source picks pin or internal clock
// - Lower timer syncs pin after prescaler
// - Upper timer syncs pin before prescaler
// - Mode decoded from source and gate bits
//////////////////////////////////////////////////////////////////////////////
package ctp_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_LO_CTRL  = 8'h00;
   localparam logic [7:0] OFS_UP_CTRL  = 8'h04;
   localparam logic [7:0] OFS_LO_COUNT = 8'h08;
   localparam logic [7:0] OFS_UP_COUNT = 8'h0c;
   localparam logic [7:0] OFS_LO_PER   = 8'h10;
   localparam logic [7:0] OFS_UP_PER   = 8'h14;
   localparam logic [7:0] OFS_STATUS   = 8'h18;
   localparam logic [7:0] OFS_MASK     = 8'h1c;
   localparam logic [7:0] OFS_PRIO     = 8'h20;

   // Control register fields
   localparam int BIT_RUN       = 15;
   localparam int BIT_IDLE_STOP = 13;
   localparam int BIT_GATE      = 6;
   localparam int BIT_PS_HI     = 5;
   localparam int BIT_PS_LO     = 4;
   localparam int BIT_PAIR_JOIN = 3;
   localparam int BIT_CLK_SRC   = 1;

   // Writable bits; unimplemented bits read as zero
   localparam logic [15:0] LO_CTRL_WMASK = 16'ha07a;
   localparam logic [15:0] UP_CTRL_WMASK = 16'ha072;

   // Status and mask layout
   localparam int ST_LO = 0;
   localparam int ST_UP = 1;
   localparam int ST_W  = 2;

   localparam int PRIO_W = 3;

   // Reset values
   localparam logic [15:0]       CTRL_RST   = 16'h0000;
   localparam logic [15:0]       COUNT_RST  = 16'h0000;
   localparam logic [15:0]       PER_RST    = 16'hffff;
   localparam logic [ST_W-1:0]   STAT_RST   = 2'h0;
   localparam logic [PRIO_W-1:0] PRIO_RST   = 3'h0;

   // Prescale encodings and terminal counts (ratio minus one)
   localparam logic [1:0] PS_1   = 2'h0;
   localparam logic [1:0] PS_8   = 2'h1;
   localparam logic [1:0] PS_64  = 2'h2;
   localparam logic [1:0] PS_256 = 2'h3;
   localparam logic [7:0] PS_LAST_1   = 8'h00;
   localparam logic [7:0] PS_LAST_8   = 8'h07;
   localparam logic [7:0] PS_LAST_64  = 8'h3f;
   localparam logic [7:0] PS_LAST_256 = 8'hff;

   function automatic logic [7:0] ps_last(input logic [1:0] ps);
      logic [7:0] r;
      unique case (ps)
         PS_1:    r = PS_LAST_1;
         PS_8:    r = PS_LAST_8;
         PS_64:   r = PS_LAST_64;
         PS_256:  r = PS_LAST_256;
      endcase
      return r;
   endfunction : ps_last

   // Byte-lane merge of a 16-bit register with a write mask
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] dat,
                                           input logic [3:0]  sel,
                                           input logic [15:0] wmask);
      logic [15:0] nw;
      nw = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
      return (nw & wmask) | (old & ~wmask);
   endfunction : merge16

endpackage : ctp_pkg

// ==== ctp_prescaler.sv ====
// Clock source, gate and prescaler stage of one 16-bit timer half
`timescale 1ns/1ps
module ctp_prescaler #(
   parameter bit SYNC_BEFORE = 1'b0
) (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       en_i,
   input  wire logic       clock_source_i,
   input  wire logic       gate_enable_i,
   input  wire logic [1:0] prescale_select_i,
   input  wire logic       pin_i,
   output logic            tick_o
);

   logic [7:0] pre_cnt;
   logic       ext_edge;
   logic       gate_level;
   logic       count_event;
   logic       pre_done;

   generate
      if (SYNC_BEFORE) begin : g_sync_before
         logic s1, s2, s3;
         // Pin is retimed ahead of the prescaler
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               s1 <= 1'b0;
               s2 <= 1'b0;
               s3 <= 1'b0;
            end else begin
               s1 <= pin_i;
               s2 <= s1;
               s3 <= s2;
            end
         end
         assign ext_edge   = s2 & ~s3;
         assign gate_level = s2;
         assign tick_o     = pre_done;
      end else begin : g_sync_after
         logic p_q, tick_q;
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               p_q    <= 1'b0;
               tick_q <= 1'b0;
            end else begin
               p_q    <= pin_i;
               tick_q <= pre_done;
            end
         end
         assign ext_edge   = pin_i & ~p_q;
         assign gate_level = pin_i;
         assign tick_o     = tick_q;
      end
   endgenerate

   // Internal clock counts every cycle, or only pin-high cycles when gated; gate ignored with pin source
   assign count_event = clock_source_i ? ext_edge
                                       : (gate_enable_i ? gate_level : 1'b1);
   assign pre_done = en_i & count_event &
                     (pre_cnt >= ctp_pkg::ps_last(prescale_select_i));

   // Cleared while stopped so a restart begins a full prescale period
   always_ff @(posedge clk_i) begin
      if (rst_i || !en_i) begin
         pre_cnt <= 8'h00;
      end else if (count_event) begin
         pre_cnt <= pre_done ? 8'h00 : pre_cnt + 8'h01;
      end
   end

endmodule : ctp_prescaler

// ==== ctp_timer_pair.sv ====
// Cascadable 16/32-bit timer pair with Wishbone register slave
//
// Decided for this implementation: the address map and the Wishbone slave port.
`timescale 1ns/1ps
module ctp_timer_pair #(
   parameter int ADDR_W = 8
) (
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   input  wire logic [ADDR_W-1:0]         wb_adr_i,
   input  wire logic [31:0]               wb_dat_i,
   input  wire logic [3:0]                wb_sel_i,
   input  wire logic                      wb_we_i,
   input  wire logic                      wb_cyc_i,
   input  wire logic                      wb_stb_i,
   output logic [31:0]                    wb_dat_o,
   output logic                           wb_ack_o,
   input  wire logic                      ext_timer_clock_pin_lo_i,
   input  wire logic                      ext_timer_clock_pin_up_i,
   input  wire logic                      idle_i,
   output logic                           irq_o,
   output logic [ctp_pkg::PRIO_W-1:0]     upper_timer_int_priority_o
);

   //////////////////////////////////////////////////////////////////////////
   // Registers and state

   logic [15:0]               lower_timer_control;
   logic [15:0]               upper_timer_control;
   logic [15:0]               lower_count_word;
   logic [15:0]               upper_count_word;
   logic [15:0]               lower_period_word;
   logic [15:0]               upper_period_word;
   logic [ctp_pkg::ST_W-1:0]  int_status;
   logic [ctp_pkg::ST_W-1:0]  int_mask;
   logic [ctp_pkg::PRIO_W-1:0] upper_timer_int_priority;

   logic        ack_q;
   logic [31:0] rd_q;
   logic        bus_req;
   logic        bus_wr;
   logic [7:0]  bus_ofs;

   logic        pair_join;
   logic        lo_en;
   logic        up_en;
   logic        tick_lo;
   logic        tick_up;
   logic [31:0] count32;
   logic [31:0] period32;
   logic        match32;

   logic [15:0]              next_lo_cnt;
   logic [15:0]              next_up_cnt;
   logic [ctp_pkg::ST_W-1:0] next_set;
   logic [ctp_pkg::ST_W-1:0] next_clr;

   function automatic logic hit(input logic [7:0] ofs, input logic [7:0] reg_ofs);
      return ofs == reg_ofs;
   endfunction : hit

   //////////////////////////////////////////////////////////////////////////
   // Wishbone slave: one wait state, unmapped reads return zero

   assign bus_req  = wb_cyc_i & wb_stb_i & ~ack_q;
   assign bus_wr   = bus_req & wb_we_i;
   assign bus_ofs  = {wb_adr_i[7:2], 2'b00};
   assign wb_ack_o = ack_q;
   assign wb_dat_o = rd_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= bus_req;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_q <= 32'h0000_0000;
      end else if (bus_req && !wb_we_i) begin
         unique case (bus_ofs)
            ctp_pkg::OFS_LO_CTRL:  rd_q <= {16'h0000, lower_timer_control};
            ctp_pkg::OFS_UP_CTRL:  rd_q <= {16'h0000, upper_timer_control};
            ctp_pkg::OFS_LO_COUNT: rd_q <= {16'h0000, lower_count_word};
            ctp_pkg::OFS_UP_COUNT: rd_q <= {16'h0000, upper_count_word};
            ctp_pkg::OFS_LO_PER:   rd_q <= {16'h0000, lower_period_word};
            ctp_pkg::OFS_UP_PER:   rd_q <= {16'h0000, upper_period_word};
            ctp_pkg::OFS_STATUS:   rd_q <= {30'h0, int_status};
            ctp_pkg::OFS_MASK:     rd_q <= {30'h0, int_mask};
            ctp_pkg::OFS_PRIO:     rd_q <= {29'h0, upper_timer_int_priority};
            default:               rd_q <= 32'h0000_0000;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Control, period, mask and priority registers

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lower_timer_control <= ctp_pkg::CTRL_RST;
         upper_timer_control <= ctp_pkg::CTRL_RST;
      end else if (bus_wr) begin
         if (hit(bus_ofs, ctp_pkg::OFS_LO_CTRL)) begin
            lower_timer_control <= ctp_pkg::merge16(lower_timer_control, wb_dat_i,
                                                    wb_sel_i, ctp_pkg::LO_CTRL_WMASK);
         end
         if (hit(bus_ofs, ctp_pkg::OFS_UP_CTRL)) begin
            upper_timer_control <= ctp_pkg::merge16(upper_timer_control, wb_dat_i,
                                                    wb_sel_i, ctp_pkg::UP_CTRL_WMASK);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lower_period_word <= ctp_pkg::PER_RST;
         upper_period_word <= ctp_pkg::PER_RST;
      end else if (bus_wr) begin
         if (hit(bus_ofs, ctp_pkg::OFS_LO_PER)) begin
            lower_period_word <= ctp_pkg::merge16(lower_period_word, wb_dat_i,
                                                  wb_sel_i, 16'hffff);
         end
         if (hit(bus_ofs, ctp_pkg::OFS_UP_PER)) begin
            upper_period_word <= ctp_pkg::merge16(upper_period_word, wb_dat_i,
                                                  wb_sel_i, 16'hffff);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         int_mask                 <= ctp_pkg::STAT_RST;
         upper_timer_int_priority <= ctp_pkg::PRIO_RST;
      end else if (bus_wr && wb_sel_i[0]) begin
         if (hit(bus_ofs, ctp_pkg::OFS_MASK)) begin
            int_mask <= wb_dat_i[ctp_pkg::ST_W-1:0];
         end
         if (hit(bus_ofs, ctp_pkg::OFS_PRIO)) begin
            upper_timer_int_priority <= wb_dat_i[ctp_pkg::PRIO_W-1:0];
         end
      end
   end

   assign upper_timer_int_priority_o = upper_timer_int_priority;

   //////////////////////////////////////////////////////////////////////////
   // Mode, run and idle decode

   // This instance is one fixed pair: lower half is always the low word
   assign pair_join = lower_timer_control[ctp_pkg::BIT_PAIR_JOIN];

   // Joined pair idles by the upper idle-stop bit only
   assign lo_en = lower_timer_control[ctp_pkg::BIT_RUN] &
                  ~(idle_i & (pair_join ? upper_timer_control[ctp_pkg::BIT_IDLE_STOP]
                                        : lower_timer_control[ctp_pkg::BIT_IDLE_STOP]));
   // Upper half has no run of its own while joined
   assign up_en = ~pair_join & upper_timer_control[ctp_pkg::BIT_RUN] &
                  ~(idle_i & upper_timer_control[ctp_pkg::BIT_IDLE_STOP]);

   ctp_prescaler #(
      .SYNC_BEFORE (1'b0)
   ) u_pre_lo (
      .clk_i             (clk_i),
      .rst_i             (rst_i),
      .en_i              (lo_en),
      .clock_source_i    (lower_timer_control[ctp_pkg::BIT_CLK_SRC]),
      .gate_enable_i     (lower_timer_control[ctp_pkg::BIT_GATE]),
      .prescale_select_i (lower_timer_control[ctp_pkg::BIT_PS_HI:ctp_pkg::BIT_PS_LO]),
      .pin_i             (ext_timer_clock_pin_lo_i),
      .tick_o            (tick_lo)
   );

   ctp_prescaler #(
      .SYNC_BEFORE (1'b1)
   ) u_pre_up (
      .clk_i             (clk_i),
      .rst_i             (rst_i),
      .en_i              (up_en),
      .clock_source_i    (upper_timer_control[ctp_pkg::BIT_CLK_SRC]),
      .gate_enable_i     (upper_timer_control[ctp_pkg::BIT_GATE]),
      .prescale_select_i (upper_timer_control[ctp_pkg::BIT_PS_HI:ctp_pkg::BIT_PS_LO]),
      .pin_i             (ext_timer_clock_pin_up_i),
      .tick_o            (tick_up)
   );

   //////////////////////////////////////////////////////////////////////////
   // Counting

   assign count32  = {upper_count_word, lower_count_word};
   assign period32 = {upper_period_word, lower_period_word};
   assign match32  = count32 == period32;

   always_comb begin
      next_lo_cnt = lower_count_word;
      next_up_cnt = upper_count_word;
      next_set    = '0;
      if (pair_join) begin
         if (tick_lo) begin
            if (match32) begin
               {next_up_cnt, next_lo_cnt} = 32'h0000_0000;
               next_set[ctp_pkg::ST_UP]   = 1'b1;
            end else begin
               {next_up_cnt, next_lo_cnt} = count32 + 32'h0000_0001;
            end
         end
      end else begin
         if (tick_lo) begin
            if (lower_count_word == lower_period_word) begin
               next_lo_cnt              = 16'h0000;
               next_set[ctp_pkg::ST_LO] = 1'b1;
            end else begin
               next_lo_cnt = lower_count_word + 16'h0001;
            end
         end
         if (tick_up) begin
            if (upper_count_word == upper_period_word) begin
               next_up_cnt              = 16'h0000;
               next_set[ctp_pkg::ST_UP] = 1'b1;
            end else begin
               next_up_cnt = upper_count_word + 16'h0001;
            end
         end
      end
   end

   // A software write to a count word wins over the same-cycle increment
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lower_count_word <= ctp_pkg::COUNT_RST;
         upper_count_word <= ctp_pkg::COUNT_RST;
      end else begin
         lower_count_word <= (bus_wr && hit(bus_ofs, ctp_pkg::OFS_LO_COUNT))
            ? ctp_pkg::merge16(lower_count_word, wb_dat_i, wb_sel_i, 16'hffff)
            : next_lo_cnt;
         upper_count_word <= (bus_wr && hit(bus_ofs, ctp_pkg::OFS_UP_COUNT))
            ? ctp_pkg::merge16(upper_count_word, wb_dat_i, wb_sel_i, 16'hffff)
            : next_up_cnt;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Interrupt status: write one to clear, a same-cycle event wins

   assign next_clr = (bus_wr && wb_sel_i[0] && hit(bus_ofs, ctp_pkg::OFS_STATUS))
                     ? wb_dat_i[ctp_pkg::ST_W-1:0] : '0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         int_status <= ctp_pkg::STAT_RST;
      end else begin
         int_status <= (int_status & ~next_clr) | next_set;
      end
   end

   // Stale lower flag is hidden once joined
   assign irq_o = |(int_status & int_mask &
                    {1'b1, ~pair_join});

   //////////////////////////////////////////////////////////////////////////
   // Assertions

   logic sw_wr;
   logic lo_ps8_timer;
   logic lo_gated;
   assign sw_wr        = bus_wr;
   assign lo_ps8_timer = lower_timer_control[ctp_pkg::BIT_PS_HI:ctp_pkg::BIT_PS_LO] == ctp_pkg::PS_8
                         && !lower_timer_control[ctp_pkg::BIT_CLK_SRC]
                         && !lower_timer_control[ctp_pkg::BIT_GATE];
   assign lo_gated     = lo_en && !lower_timer_control[ctp_pkg::BIT_CLK_SRC]
                         && lower_timer_control[ctp_pkg::BIT_GATE];

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   AST_WRAP32: assert property (pair_join && tick_lo && match32 && !sw_wr
      |=> count32 == 32'h0000_0000)
      else $error("joined count did not wrap at period");
   AST_FLAG32: assert property (pair_join && tick_lo && match32
      |=> int_status[ctp_pkg::ST_UP])
      else $error("upper flag not set on joined wrap");
   AST_NO_LO_FLAG: assert property ((pair_join && !int_status[ctp_pkg::ST_LO]) ##1 pair_join
      |-> !int_status[ctp_pkg::ST_LO])
      else $error("lower flag set while joined");
   // A tick is still in flight one cycle after the pair halts, so both cycles must be halted
   AST_STOPPED: assert property (pair_join && !lower_timer_control[ctp_pkg::BIT_RUN]
      && !$past(lower_timer_control[ctp_pkg::BIT_RUN]) && !sw_wr |=> $stable(count32))
      else $error("joined count moved while stopped");
   AST_IDLE32: assert property (pair_join && idle_i
      && upper_timer_control[ctp_pkg::BIT_IDLE_STOP] && $past(pair_join) && $past(idle_i)
      && $past(upper_timer_control[ctp_pkg::BIT_IDLE_STOP]) && !sw_wr |=> $stable(count32))
      else $error("joined count moved in idle with stop set");
   AST_UPPER_IGNORED: assert property (pair_join && !tick_lo && !sw_wr
      |=> $stable(count32))
      else $error("joined count moved without lower tick");
   AST_PS8: assert property (disable iff (rst_i || wb_cyc_i || idle_i)
      tick_lo && lo_ps8_timer && lower_timer_control[ctp_pkg::BIT_RUN]
      |=> (!tick_lo)[*7] ##1 tick_lo)
      else $error("prescale 1:8 tick spacing wrong");
   AST_GATE_LOW: assert property ($past(lo_gated) && !$past(ext_timer_clock_pin_lo_i)
      |-> !tick_lo)
      else $error("gated timer counted with gate low");
   AST_IRQ: assert property (int_status[ctp_pkg::ST_UP] && int_mask[ctp_pkg::ST_UP]
      |-> irq_o)
      else $error("enabled upper flag did not raise interrupt");

   COV_WRAP32: cover property (pair_join && tick_lo && match32);
   COV_UP16:   cover property (!pair_join && tick_up && upper_count_word == upper_period_word);
   COV_IRQ:    cover property (!irq_o ##1 irq_o);
   COV_GATED:  cover property (lo_gated && tick_lo);

endmodule : ctp_timer_pair

// ==== ctp_pin_model.sv ====
// External clock and gate pin model for both timer halves
`timescale 1ns/1ps
module ctp_pin_model (
   input  wire logic clk_i,
   output logic      pin_lo_o,
   output logic      pin_up_o
);
   // Pins rest low between bursts, as an external clock that stands still
   initial begin
      pin_lo_o = 1'b0;
      pin_up_o = 1'b0;
   end
   // Gate: level held n cycles; clock: n rising edges of hp cycles per half
   task automatic drive(input bit up, input bit edges, input int n, input int hp);
      int  len;
      bit  lvl;
      len = edges ? 2 * n * hp : n;
      for (int i = 0; i < len; i++) begin
         @(posedge clk_i);
         lvl = edges ? ((i / hp) % 2 == 0) : 1'b1;
         if (up) pin_up_o <= lvl;
         else pin_lo_o <= lvl;
      end
      @(posedge clk_i);
      pin_lo_o <= 1'b0;
      pin_up_o <= 1'b0;
   endtask : drive
endmodule : ctp_pin_model

// ==== cascadable_timer_pair_32bit_bench.sv ====
// Self-checking bench for the cascadable timer pair
`timescale 1ns/1ps
module cascadable_timer_pair_32bit_bench;
   logic        clk_i;
   logic        rst_i;
   logic [7:0]  wb_adr_i;
   logic [31:0] wb_dat_i;
   logic [3:0]  wb_sel_i;
   logic        wb_we_i;
   logic        wb_cyc_i;
   logic        wb_stb_i;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        pin_lo;
   logic        pin_up;
   logic        idle_i;
   logic        irq_o;
   logic [2:0]  prio;
   logic [31:0] rd;
   logic [31:0] bs;
   logic [32:0] m;
   logic [2:0]  r3;
   int          n_mismatch;
   int          n_checks;
   int          c0;
   int          k;
   int          g;
   int          h;
   int ratio[4] = '{1, 8, 64, 256};
   logic [15:0] loc[4] = '{16'h2000, 16'h0000, 16'h2008, 16'h0008};
   logic [15:0] upc[4] = '{16'h0000, 16'h2000, 16'h0000, 16'h2000};
   bit          go[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
   logic [15:0] mc[3] = '{16'h0040, 16'h0042, 16'h0002};

   ctp_timer_pair u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .ext_timer_clock_pin_lo_i(pin_lo), .ext_timer_clock_pin_up_i(pin_up),
      .idle_i(idle_i), .irq_o(irq_o), .upper_timer_int_priority_o(prio));
   ctp_pin_model u_pin (.clk_i(clk_i), .pin_lo_o(pin_lo), .pin_up_o(pin_up));

   //////////////////////////////////////////////////////////////////////////////
   task automatic fail(input string s);
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, s);
   endtask : fail
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) fail($sformatf("got %h want %h", got, exp));
   endtask : chk
   // Waits for ack with no assumed latency; only the watchdog ends a hang
   task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic we);
      @(posedge clk_i);
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_we_i  <= we;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(a, d, 1'b1);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      wb(a, 32'h0, 1'b0);
      chk(rd, e);
   endtask : rdc
   task automatic run(input logic [15:0] c, input int n);
      wr(ctp_pkg::OFS_LO_CTRL, {16'h0, c | 16'h8000});
      repeat (n) @(posedge clk_i);
      wr(ctp_pkg::OFS_LO_CTRL, {16'h0, c});
   endtask : run
   // Reference count: wraps to zero on the tick after it equals the period
   function automatic logic [32:0] model(input logic [31:0] s, input logic [31:0] p, input int t);
      logic [32:0] r;
      r = {1'b0, s};
      repeat (t) r = (r[31:0] == p) ? {1'b1, 32'h0} : {r[32], r[31:0] + 32'h1};
      return r;
   endfunction : model
   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : results

   //////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   initial begin
      repeat (30000) @(posedge clk_i);
      n_mismatch++;
      results();
   end
   initial begin
      rst_i = 1'b1;
      wb_adr_i = 8'h00;
      wb_dat_i = 32'h0;
      wb_sel_i = 4'hf;
      wb_we_i = 1'b0;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      idle_i = 1'b0;
      n_mismatch = 0;
      n_checks = 0;
      // Start latency plus the span of the stop write add three ticks at 1:1
      c0 = 3;
      void'($urandom(32'h6bb5));
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rdc(ctp_pkg::OFS_LO_CTRL, 32'h0);
      rdc(ctp_pkg::OFS_UP_PER, 32'hffff);
      rdc(8'h24, 32'h0);
      wr(ctp_pkg::OFS_LO_CTRL, 32'hffff_7fff);
      rdc(ctp_pkg::OFS_LO_CTRL, 32'h207a);
      wr(ctp_pkg::OFS_LO_CTRL, 32'h0);
      wr(ctp_pkg::OFS_UP_CTRL, 32'h7fff);
      rdc(ctp_pkg::OFS_UP_CTRL, 32'h2072);
      wr(ctp_pkg::OFS_UP_CTRL, 32'h0);
      r3 = 3'($urandom);
      wr(ctp_pkg::OFS_PRIO, {29'h0, r3});
      chk({29'h0, prio}, {29'h0, r3});
      $display("registers done");
      // Same start and prescaler restart, so only the extra ratio*k cycles differ
      for (int ps = 0; ps < 4; ps++) begin
         k = $urandom_range(1, 4);
         wr(ctp_pkg::OFS_LO_COUNT, 32'h0);
         run(16'(ps << 4), 20);
         wb(ctp_pkg::OFS_LO_COUNT, 32'h0, 1'b0);
         bs = rd;
         if (ps == 0) chk(rd, 32'(20 + c0));
         wr(ctp_pkg::OFS_LO_COUNT, 32'h0);
         run(16'(ps << 4), 20 + k * ratio[ps]);
         wb(ctp_pkg::OFS_LO_COUNT, 32'h0, 1'b0);
         chk(rd - bs, 32'(k));
      end
      $display("prescale done");
      wr(ctp_pkg::OFS_LO_PER, 32'($urandom_range(3, 9)));
      wb(ctp_pkg::OFS_LO_PER, 32'h0, 1'b0);
      g = $urandom_range(12, 30);
      wr(ctp_pkg::OFS_LO_COUNT, 32'h0);
      run(16'h0000, g);
      m = model(32'h0, rd, g + c0);
      rdc(ctp_pkg::OFS_LO_COUNT, {16'h0, m[15:0]});
      rdc(ctp_pkg::OFS_UP_COUNT, 32'h0);
      rdc(ctp_pkg::OFS_STATUS, {31'h0, m[32]});
      chk({31'h0, irq_o}, 32'h0);
      wr(ctp_pkg::OFS_MASK, 32'h1);
      chk({31'h0, irq_o}, {31'h0, m[32]});
      wr(ctp_pkg::OFS_STATUS, 32'h1);
      rdc(ctp_pkg::OFS_STATUS, 32'h0);
      chk({31'h0, irq_o}, 32'h0);
      $display("wrap done");
      wr(ctp_pkg::OFS_LO_CTRL, 32'h0008);
      wr(ctp_pkg::OFS_UP_CTRL, 32'h8032);
      wr(ctp_pkg::OFS_LO_PER, 32'h2);
      wr(ctp_pkg::OFS_UP_PER, 32'h1);
      wr(ctp_pkg::OFS_MASK, 32'h3);
      wr(ctp_pkg::OFS_LO_COUNT, 32'hfffd);
      wr(ctp_pkg::OFS_UP_COUNT, 32'h0);
      g = $urandom_range(1, 12);
      run(16'h0008, g);
      m = model(32'h0000_fffd, 32'h0001_0002, g + c0);
      rdc(ctp_pkg::OFS_LO_COUNT, {16'h0, m[15:0]});
      rdc(ctp_pkg::OFS_UP_COUNT, {16'h0, m[31:16]});
      rdc(ctp_pkg::OFS_STATUS, {30'h0, m[32], 1'b0});
      chk({31'h0, irq_o}, {31'h0, m[32]});
      wr(ctp_pkg::OFS_STATUS, 32'h3);
      wr(ctp_pkg::OFS_LO_PER, 32'hffff);
      wr(ctp_pkg::OFS_UP_PER, 32'hffff);
      $display("joined done");
      idle_i <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         wr(ctp_pkg::OFS_UP_CTRL, {16'h0, upc[i]});
         wr(ctp_pkg::OFS_LO_COUNT, 32'h0);
         wr(ctp_pkg::OFS_UP_COUNT, 32'h0);
         run(loc[i], 10);
         rdc(ctp_pkg::OFS_LO_COUNT, 32'(go[i] ? 10 + c0 : 0));
      end
      idle_i <= 1'b0;
      $display("idle done");
      wr(ctp_pkg::OFS_LO_CTRL, 32'h0);
      wr(ctp_pkg::OFS_UP_CTRL, 32'h0);
      // Gate counts high cycles, counter counts edges: pulses tell them apart
      for (int i = 0; i < 3; i++) begin
         h = $urandom_range(2, 9);
         wr(ctp_pkg::OFS_LO_COUNT, 32'h0);
         wr(ctp_pkg::OFS_UP_COUNT, 32'h0);
         wr(i == 2 ? ctp_pkg::OFS_UP_CTRL : ctp_pkg::OFS_LO_CTRL, {16'h0, mc[i] | 16'h8000});
         u_pin.drive(i == 2, i > 0, h, $urandom_range(1, 3));
         repeat (8) @(posedge clk_i);
         wr(i == 2 ? ctp_pkg::OFS_UP_CTRL : ctp_pkg::OFS_LO_CTRL, {16'h0, mc[i]});
         rdc(i == 2 ? ctp_pkg::OFS_UP_COUNT : ctp_pkg::OFS_LO_COUNT, 32'(h));
      end
      $display("pin modes done");
      results();
   end
endmodule : cascadable_timer_pair_32bit_bench
